// >>> fdc_drive_ctl.sv
// drive control commands: timing setup, configuration, seeks, transfers
`timescale 1ns/1ps
`default_nettype none
`include "fdc_defs.svh"

module fdc_drive_ctl
   import fdc_pkg::*;
#(
   parameter int TICK_2M_CYC = `FDC_TICK_NS / `FDC_CLK_NS,
   parameter logic [7:0] VERSION_ID = 8'h5a // arbitrary value
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [`FDC_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic home_track_sense,
   output logic step_pulse,
   output logic step_dir,
   output logic head_load,
   output logic dma_request_line,
   output logic controller_irq,
   output logic precomp_enable,
   output logic fifo_enable,
   output logic [4:0] fifo_threshold
);

   fdc_timing_s timing_reg;
   fdc_config_s config_reg;
   fdc_rate_e rate_reg;
   fdc_state_e state_reg;
   fdc_op_e op_reg;
   fdc_cmd_s cmd_w;
   logic [31:0] tick_lim;
   logic [31:0] div_cnt_reg;
   logic tick_reg;
   logic [8:0] wait_reg;
   logic [8:0] hut_cnt_reg;
   logic [7:0] pcn_reg;
   logic [7:0] target_reg;
   logic [7:0] steps_left_reg;
   logic [6:0] recal_cnt_reg;
   logic [7:0] bytes_left_reg;
   logic [4:0] burst_left_reg;
   logic [4:0] burst_size;
   logic way_reg;
   logic se_reg;
   logic fault_reg;
   logic [1:0] ic_reg;
   logic rqm_reg;
   logic req_on_reg;
   logic poll_pend_reg;
   logic step_reg;
   logic dir_reg;
   logic head_reg;
   logic dma_reg;
   logic irq_reg;
   logic [31:0] rdata_reg;
   logic precomp_reg;
   logic fifo_en_reg;
   logic [4:0] fifo_thr_reg;
   logic cmd_go;
   logic ack;
   logic status_rd;

   assign cmd_w = reg_wdata[23:0];
   // a command is refused unless idle, so relative seeks never stack
   assign cmd_go = reg_wr && reg_addr == `FDC_OFF_CMD
      && state_reg == FDC_IDLE;
   assign ack = reg_wr && reg_addr == `FDC_OFF_XFER_ACK
      && state_reg == FDC_XFER && req_on_reg;
   assign status_rd = reg_rd && reg_addr == `FDC_OFF_STATUS;
   // bypass forces one byte per request
   assign burst_size = config_reg.queue_bypass ? 5'h01
      : {1'b0, config_reg.queue_level} + 5'h01;

   // time base period is scaled by 2M/rate
   always_comb begin
      case (rate_reg)
         FDC_RATE_2M: tick_lim = TICK_2M_CYC;
         FDC_RATE_1M: tick_lim = TICK_2M_CYC * 2;
         FDC_RATE_500K: tick_lim = TICK_2M_CYC * 4;
         FDC_RATE_300K: tick_lim = (TICK_2M_CYC * 20) / 3;
         default: tick_lim = TICK_2M_CYC * 8;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         div_cnt_reg <= 32'h0;
         tick_reg <= 1'b0;
      end else if (div_cnt_reg >= tick_lim - 32'h1) begin
         div_cnt_reg <= 32'h0;
         tick_reg <= 1'b1;
      end else begin
         div_cnt_reg <= div_cnt_reg + 32'h1;
         tick_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         timing_reg <= `FDC_TIMING_RST;
         config_reg <= `FDC_CONFIG_RST;
         rate_reg <= fdc_rate_e'(`FDC_RATE_RST);
      end else if (reg_wr) begin
         case (reg_addr)
            `FDC_OFF_TIMING: timing_reg <= reg_wdata[15:0];
            `FDC_OFF_CONFIG: config_reg <= reg_wdata[15:0];
            `FDC_OFF_RATE: rate_reg <= fdc_rate_e'(reg_wdata[2:0]);
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg <= FDC_IDLE;
         op_reg <= FDC_OP_SEEK;
         wait_reg <= 9'h0;
         hut_cnt_reg <= 9'h0;
         pcn_reg <= 8'h0;
         target_reg <= 8'h0;
         steps_left_reg <= 8'h0;
         recal_cnt_reg <= 7'h0;
         bytes_left_reg <= 8'h0;
         burst_left_reg <= 5'h0;
         way_reg <= 1'b0;
         se_reg <= 1'b0;
         fault_reg <= 1'b0;
         ic_reg <= `FDC_IC_NORMAL;
         rqm_reg <= 1'b0;
         req_on_reg <= 1'b0;
         poll_pend_reg <= 1'b1;
         step_reg <= 1'b0;
         dir_reg <= 1'b0;
         head_reg <= 1'b0;
         dma_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         step_reg <= 1'b0;
         // clear first; any set below overrides it in the same cycle
         if (status_rd) begin
            irq_reg <= 1'b0;
         end
         if (tick_reg && wait_reg != 9'h0) begin
            wait_reg <= wait_reg - 9'h1;
         end
         if (tick_reg && hut_cnt_reg != 9'h0) begin
            hut_cnt_reg <= hut_cnt_reg - 9'h1;
            if (hut_cnt_reg == 9'h1) begin
               head_reg <= 1'b0;
            end
         end
         case (state_reg)
            FDC_IDLE: begin
               if (cmd_go) begin
                  op_reg <= fdc_op_e'(cmd_w.op);
                  way_reg <= cmd_w.step_way;
                  target_reg <= cmd_w.cylinder;
                  steps_left_reg <= cmd_w.cylinder;
                  bytes_left_reg <= cmd_w.xfer_len;
                  recal_cnt_reg <= 7'h0;
                  wait_reg <= 9'h0;
                  se_reg <= 1'b0;
                  fault_reg <= 1'b0;
                  ic_reg <= `FDC_IC_NORMAL;
                  if (fdc_op_e'(cmd_w.op) == FDC_OP_RW
                      && !config_reg.auto_position_enable) begin
                     state_reg <= FDC_HEADLOAD;
                  end else begin
                     state_reg <= FDC_STEPPING;
                  end
                  if (fdc_op_e'(cmd_w.op) == FDC_OP_RECAL) begin
                     pcn_reg <= 8'h0;
                  end
               end else if (poll_pend_reg) begin
                  if (config_reg.drive_status_survey_off) begin
                     poll_pend_reg <= 1'b0;
                  end else if (!head_reg) begin
                     poll_pend_reg <= 1'b0;
                     irq_reg <= 1'b1;
                     ic_reg <= `FDC_IC_POLL;
                  end
               end
            end
            FDC_STEPPING: begin
               if (wait_reg == 9'h0) begin
                  // next step waits 16 - step_interval ticks of the free-running time base; the first may be partial
                  wait_reg <= {4'h0, `FDC_SRT_SPAN
                     - {1'b0, timing_reg.step_interval}};
                  case (op_reg)
                     FDC_OP_REL: begin
                        if (steps_left_reg == 8'h0) begin
                           state_reg <= FDC_IDLE;
                           se_reg <= 1'b1;
                           irq_reg <= 1'b1;
                        end else if (!way_reg && home_track_sense) begin
                           state_reg <= FDC_IDLE;
                           se_reg <= 1'b1;
                           fault_reg <= 1'b1;
                           ic_reg <= `FDC_IC_ABNORMAL;
                           irq_reg <= 1'b1;
                        end else begin
                           step_reg <= 1'b1;
                           dir_reg <= way_reg;
                           steps_left_reg <= steps_left_reg - 8'h1;
                           // 8-bit wrap gives modulo 256 tracking
                           pcn_reg <= way_reg ? pcn_reg + 8'h1
                              : pcn_reg - 8'h1;
                        end
                     end
                     FDC_OP_RECAL: begin
                        if (home_track_sense) begin
                           state_reg <= FDC_IDLE;
                           se_reg <= 1'b1;
                           irq_reg <= 1'b1;
                        end else if (recal_cnt_reg == `FDC_RECAL_MAX) begin
                           state_reg <= FDC_IDLE;
                           se_reg <= 1'b1;
                           fault_reg <= 1'b1;
                           ic_reg <= `FDC_IC_ABNORMAL;
                           irq_reg <= 1'b1;
                        end else begin
                           step_reg <= 1'b1;
                           dir_reg <= 1'b0;
                           recal_cnt_reg <= recal_cnt_reg + 7'h1;
                        end
                     end
                     default: begin
                        if (pcn_reg == target_reg) begin
                           if (op_reg == FDC_OP_RW) begin
                              state_reg <= FDC_HEADLOAD;
                              wait_reg <= 9'h0;
                           end else begin
                              state_reg <= FDC_IDLE;
                              se_reg <= 1'b1;
                              irq_reg <= 1'b1;
                           end
                        end else begin
                           step_reg <= 1'b1;
                           dir_reg <= pcn_reg < target_reg;
                           pcn_reg <= pcn_reg < target_reg
                              ? pcn_reg + 8'h1 : pcn_reg - 8'h1;
                        end
                     end
                  endcase
               end
            end
            FDC_HEADLOAD: begin
               if (!head_reg) begin
                  head_reg <= 1'b1;
                  hut_cnt_reg <= 9'h0;
                  wait_reg <= timing_reg.head_load_delay == 7'h0
                     ? `FDC_CODE0_TICKS
                     : {2'h0, timing_reg.head_load_delay}
                       * `FDC_HLT_UNIT;
               end else if (wait_reg == 9'h0) begin
                  hut_cnt_reg <= 9'h0;
                  state_reg <= FDC_XFER;
                  burst_left_reg <= burst_size;
               end
            end
            FDC_XFER: begin
               if (!req_on_reg) begin
                  req_on_reg <= 1'b1;
                  dma_reg <= !timing_reg.byte_transfer_mode;
                  if (timing_reg.byte_transfer_mode) begin
                     rqm_reg <= 1'b1;
                     irq_reg <= 1'b1;
                  end
               end else if (ack) begin
                  bytes_left_reg <= bytes_left_reg - 8'h1;
                  burst_left_reg <= burst_left_reg - 5'h1;
                  if (bytes_left_reg == 8'h0 || burst_left_reg == 5'h1) begin
                     req_on_reg <= 1'b0;
                     dma_reg <= 1'b0;
                     rqm_reg <= 1'b0;
                     burst_left_reg <= burst_size;
                  end
                  if (bytes_left_reg == 8'h0) begin
                     state_reg <= FDC_IDLE;
                     hut_cnt_reg <= timing_reg.head_unload_delay == 4'h0
                        ? `FDC_CODE0_TICKS
                        : {5'h0, timing_reg.head_unload_delay}
                          * `FDC_HUT_UNIT;
                  end
               end
            end
            default: state_reg <= FDC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= 32'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            `FDC_OFF_TIMING: rdata_reg <= {16'h0, timing_reg};
            `FDC_OFF_CONFIG: rdata_reg <= {16'h0, config_reg};
            `FDC_OFF_RATE: rdata_reg <= {29'h0, rate_reg};
            `FDC_OFF_STATUS: begin
               rdata_reg <= 32'h0;
               rdata_reg[`FDC_ST_PCN_LSB +: 8] <= pcn_reg;
               rdata_reg[`FDC_ST_IC_LSB +: 2] <= ic_reg;
               rdata_reg[`FDC_ST_SE_BIT] <= se_reg;
               rdata_reg[`FDC_ST_FAULT_BIT] <= fault_reg;
               rdata_reg[`FDC_ST_RQM_BIT] <= rqm_reg;
               rdata_reg[`FDC_ST_BUSY_BIT] <= state_reg != FDC_IDLE;
               rdata_reg[`FDC_ST_HEAD_BIT] <= head_reg;
            end
            `FDC_OFF_VERSION: rdata_reg <= {24'h0, VERSION_ID};
            default: rdata_reg <= 32'h0;
         endcase
      end else begin
         rdata_reg <= 32'h0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         precomp_reg <= 1'b0;
         fifo_en_reg <= 1'b0;
         fifo_thr_reg <= 5'h01;
      end else begin
         precomp_reg <= pcn_reg >= config_reg.precomp_start_cylinder;
         fifo_en_reg <= !config_reg.queue_bypass;
         fifo_thr_reg <= burst_size;
      end
   end

   assign reg_rdata = rdata_reg;
   assign step_pulse = step_reg;
   assign step_dir = dir_reg;
   assign head_load = head_reg;
   assign dma_request_line = dma_reg;
   assign controller_irq = irq_reg;
   assign precomp_enable = precomp_reg;
   assign fifo_enable = fifo_en_reg;
   assign fifo_threshold = fifo_thr_reg;

   // helper: cycles since the previous step of the current command
   logic [31:0] gap_cnt_reg;
   logic gap_valid_reg;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         gap_cnt_reg <= 32'h0;
         gap_valid_reg <= 1'b0;
      end else if (state_reg != FDC_STEPPING) begin
         gap_cnt_reg <= 32'h0;
         gap_valid_reg <= 1'b0;
      end else if (step_reg) begin
         gap_cnt_reg <= 32'h1;
         gap_valid_reg <= 1'b1;
      end else begin
         gap_cnt_reg <= gap_cnt_reg + 32'h1;
      end
   end

   a_step_gap_min: assert property (@(posedge clk_sys) disable iff (!resetn)
      step_reg && gap_valid_reg |-> gap_cnt_reg >= 32'(15
         - timing_reg.step_interval) * tick_lim)
      else $error("step pulses too close");
   a_recal_out_dir: assert property (@(posedge clk_sys) disable iff (!resetn)
      step_reg && op_reg == FDC_OP_RECAL |-> !dir_reg)
      else $error("recalibrate stepped inward");
   a_rel_way_dir: assert property (@(posedge clk_sys) disable iff (!resetn)
      step_reg && op_reg == FDC_OP_REL |-> dir_reg == way_reg)
      else $error("relative seek direction wrong");
   a_rel_pcn_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
      state_reg == FDC_STEPPING && op_reg == FDC_OP_REL && way_reg
      && wait_reg == 9'h0 && steps_left_reg != 8'h0 && pcn_reg == 8'hff
      |=> pcn_reg == 8'h00)
      else $error("cylinder did not wrap");
   a_seek_end_irq: assert property (@(posedge clk_sys) disable iff (!resetn)
      state_reg == FDC_STEPPING && op_reg != FDC_OP_RW
      ##1 state_reg == FDC_IDLE |-> irq_reg && se_reg)
      else $error("no interrupt at seek end");
   a_dma_mode_only: assert property (@(posedge clk_sys) disable iff (!resetn)
      dma_reg |-> !timing_reg.byte_transfer_mode && !rqm_reg)
      else $error("dma request in non-dma mode");
   a_rqm_with_irq: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(rqm_reg) |-> irq_reg && timing_reg.byte_transfer_mode)
      else $error("byte request without interrupt");
   a_version_byte: assert property (@(posedge clk_sys) disable iff (!resetn)
      reg_rd && reg_addr == `FDC_OFF_VERSION
      |=> reg_rdata == {24'h0, VERSION_ID})
      else $error("wrong version byte");
   a_fault_cause: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(fault_reg) |-> ic_reg == `FDC_IC_ABNORMAL
      && $past(home_track_sense) != (op_reg == FDC_OP_RECAL))
      else $error("fault raised without cause");
   a_poll_head: assert property (@(posedge clk_sys) disable iff (!resetn)
      $fell(poll_pend_reg) && !config_reg.drive_status_survey_off
      |-> !head_reg && irq_reg)
      else $error("poll while head loaded");

endmodule
`default_nettype wire

// >>> fdc_defs.svh
// register offsets, field positions, reset values and timing constants
`ifndef FDC_DEFS_SVH
`define FDC_DEFS_SVH

`define FDC_ADDR_W 3
`define FDC_OFF_TIMING 3'h0
`define FDC_OFF_CONFIG 3'h1
`define FDC_OFF_RATE 3'h2
`define FDC_OFF_CMD 3'h3
`define FDC_OFF_STATUS 3'h4
`define FDC_OFF_VERSION 3'h5
`define FDC_OFF_XFER_ACK 3'h6

// status word layout
`define FDC_ST_HEAD_BIT 1
`define FDC_ST_BUSY_BIT 2
`define FDC_ST_RQM_BIT 3
`define FDC_ST_FAULT_BIT 4
`define FDC_ST_SE_BIT 5
`define FDC_ST_IC_LSB 6
`define FDC_ST_PCN_LSB 8

`define FDC_TIMING_RST 16'h0000
`define FDC_CONFIG_RST 16'h0002
`define FDC_RATE_RST 3'h2

`define FDC_IC_NORMAL 2'h0
`define FDC_IC_ABNORMAL 2'h1
`define FDC_IC_POLL 2'h3

// one time-base tick is 0.25 ms at the 2 Mbps rate
`define FDC_CLK_NS 5
`define FDC_TICK_NS 250000
`define FDC_SRT_SPAN 5'h10
`define FDC_HUT_UNIT 9'h010
`define FDC_HLT_UNIT 9'h002
`define FDC_CODE0_TICKS 9'h100
`define FDC_RECAL_MAX 7'h50

`endif

// >>> fdc_pkg.sv
// types shared by the drive control command block
`default_nettype none
package fdc_pkg;

   typedef enum logic [1:0] {
      FDC_IDLE,
      FDC_STEPPING,
      FDC_HEADLOAD,
      FDC_XFER
   } fdc_state_e;

   typedef enum logic [1:0] {
      FDC_OP_SEEK,
      FDC_OP_REL,
      FDC_OP_RECAL,
      FDC_OP_RW
   } fdc_op_e;

   typedef enum logic [2:0] {
      FDC_RATE_2M,
      FDC_RATE_1M,
      FDC_RATE_500K,
      FDC_RATE_300K,
      FDC_RATE_250K
   } fdc_rate_e;

   typedef struct packed {
      logic byte_transfer_mode;
      logic [6:0] head_load_delay;
      logic [3:0] head_unload_delay;
      logic [3:0] step_interval;
   } fdc_timing_s;

   typedef struct packed {
      logic [7:0] precomp_start_cylinder;
      logic [3:0] queue_level;
      logic rsvd;
      logic drive_status_survey_off;
      logic queue_bypass;
      logic auto_position_enable;
   } fdc_config_s;

   typedef struct packed {
      logic [7:0] xfer_len;
      logic [7:0] cylinder;
      logic step_way;
      logic [4:0] rsvd;
      logic [1:0] op;
   } fdc_cmd_s;

endpackage
`default_nettype wire

// >>> fdc_drive_model.sv
// behavioural floppy drive: head position and home sensor
`timescale 1ns/1ps
`default_nettype none
module fdc_drive_model #(
   parameter int START_POS = 0
) (
   input wire logic clk_sys,
   input wire logic step_pulse,
   input wire logic step_dir,
   output logic home_track_sense
);
   int pos = START_POS;
   // hard stop at the outer end; no upper stop, extended tracks allowed
   always @(posedge clk_sys) begin
      if (step_pulse === 1'b1) begin
         if (step_dir === 1'b1) begin
            pos <= pos + 1;
         end else if (pos > 0) begin
            pos <= pos - 1;
         end
      end
   end
   assign home_track_sense = (pos == 0);
endmodule
`default_nettype wire

// >>> tb_fdc_drive_control_commands.sv
// self-checking bench for the drive control command block
`timescale 1ns/1ps
`default_nettype none
`include "fdc_defs.svh"
module tb_fdc_drive_control_commands;
   import fdc_pkg::*;
   localparam logic [7:0] VER = 8'h3c; // arbitrary value
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, st;
   logic home_track_sense, step_pulse, step_dir, head_load;
   logic dma_request_line, controller_irq, precomp_enable, fifo_enable;
   logic [4:0] fifo_threshold;
   int n_mismatch = 0;
   int n_compared = 0;
   int n_steps = 0;
   int gap = 0;
   int cyc = 0;
   int last = 0;
   int t = 0;
   always #2.5 clk_sys = ~clk_sys;
   fdc_drive_ctl #(.TICK_2M_CYC(4), .VERSION_ID(VER)) uut (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .home_track_sense(home_track_sense),
      .step_pulse(step_pulse),
      .step_dir(step_dir),
      .head_load(head_load),
      .dma_request_line(dma_request_line),
      .controller_irq(controller_irq),
      .precomp_enable(precomp_enable),
      .fifo_enable(fifo_enable),
      .fifo_threshold(fifo_threshold)
   );
   fdc_drive_model drv (
      .clk_sys(clk_sys),
      .step_pulse(step_pulse),
      .step_dir(step_dir),
      .home_track_sense(home_track_sense)
   );
   // gap holds the spacing of the two most recent pulses
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (step_pulse === 1'b1) begin
         n_steps <= n_steps + 1;
         gap <= cyc - last;
         last <= cyc;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   function automatic logic pick(input int w);
      case (w)
         0: return controller_irq;
         1: return head_load;
         default: return dma_request_line;
      endcase
   endfunction
   // t ends as the number of cycles waited
   task automatic wait_sig(input int w, input logic lvl);
      t = 0;
      while (pick(w) !== lvl && t < 6000) begin
         @(posedge clk_sys);
         t++;
      end
      chk(pick(w), lvl);
   endtask
   // stale interrupt read off first; a2 gets a second write while busy
   task automatic run_cmd(input logic [31:0] c, input logic [2:0] a2,
                          input int n);
      rd(`FDC_OFF_STATUS, st);
      n_steps = 0;
      wr(`FDC_OFF_CMD, c);
      wr(a2, c ^ 32'h0000_3000);
      wait_sig(0, 1'b1);
      rd(`FDC_OFF_STATUS, st);
      if (n >= 0) chk(n_steps, n);
   endtask
   task automatic tally_and_finish;
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      wait_sig(0, 1'b1);
      rd(`FDC_OFF_STATUS, st);
      chk(st[7:5], {`FDC_IC_POLL, 1'b0});
      chk({fifo_enable, fifo_threshold, precomp_enable}, 7'h03);
      repeat (20) @(posedge clk_sys);
      chk(controller_irq, 1'b0);
      rd(`FDC_OFF_VERSION, st);
      chk(st, {24'h0, VER});
      rd(3'h7, st);
      chk(st, 32'h0);
      wr(`FDC_OFF_CONFIG, 32'h0000_03f0);
      wr(`FDC_OFF_TIMING, 32'h0000_011e);
      wr(`FDC_OFF_RATE, 32'h0);
      @(posedge clk_sys);
      chk({fifo_enable, fifo_threshold, precomp_enable}, 7'h60);
      // second relative seek while busy must be dropped
      run_cmd(32'h0000_0381, `FDC_OFF_CMD, 3);
      chk(st[15:5], {8'h03, `FDC_IC_NORMAL, 1'b1});
      chk(step_dir, 1'b1);
      chk(gap >= 4 && gap <= 8, 1'b1);
      chk(precomp_enable, 1'b1);
      wr(`FDC_OFF_RATE, 32'h1);
      run_cmd(32'h0000_0381, 3'h7, 3);
      chk(st[15:8], 8'h06);
      chk(gap >= 8 && gap <= 16, 1'b1);
      wr(`FDC_OFF_RATE, 32'h0);
      run_cmd(32'h0000_0901, 3'h7, -1);
      chk(st[`FDC_ST_FAULT_BIT], 1'b1);
      chk(st[7:6], `FDC_IC_ABNORMAL);
      chk(step_dir, 1'b0);
      run_cmd(32'h0000_0002, 3'h7, 0);
      chk(st[15:5], {8'h00, `FDC_IC_NORMAL, 1'b1});
      // host works out the track difference itself
      run_cmd(32'h0000_fa81, 3'h7, 250);
      run_cmd(32'h0000_0a81, 3'h7, 10);
      chk(st[15:8], 8'h04);
      run_cmd(32'h0000_0200, 3'h7, 2);
      chk(st[15:8], 8'h02);
      run_cmd(32'h0000_0002, 3'h7, 80);
      chk(st[7:6], `FDC_IC_ABNORMAL);
      rd(`FDC_OFF_STATUS, st);
      wr(`FDC_OFF_CMD, 32'h0000_0003);
      wait_sig(1, 1'b1);
      wait_sig(2, 1'b1);
      chk(t >= 4 && t <= 12, 1'b1);
      wr(`FDC_OFF_XFER_ACK, 32'h0);
      wait_sig(2, 1'b0);
      wait_sig(1, 1'b0);
      chk(t >= 56 && t <= 70, 1'b1);
      wr(`FDC_OFF_TIMING, 32'h0000_811e);
      wr(`FDC_OFF_CONFIG, 32'h0000_0003);
      run_cmd(32'h0000_0603, 3'h7, -1);
      repeat (30) @(posedge clk_sys);
      rd(`FDC_OFF_STATUS, st);
      chk(st[`FDC_ST_RQM_BIT], 1'b1);
      chk(st[15:8], 8'h06);
      chk({dma_request_line, fifo_threshold}, 6'h01);
      wr(`FDC_OFF_XFER_ACK, 32'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
